// ==== etc_chk.sv ====
`timescale 1ns/100ps
`default_nettype none
// ----
// exposure checks
// ----
module etc_chk (
	// clock and reset
	input wire logic              mclk,
	input wire logic              rst_b,
	// inputs
	input wire etc_pkg::etc_cfg_t cfg,
	input wire logic              trigger_in,
	input wire logic              image_out_busy,
	// outputs
	input wire logic              exposure_active,
	input wire logic              exposure_start,
	input wire logic              line_tick,
	input wire logic              trigger_filtered
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);
	// a start must come from a fresh filtered edge
	sequence s_rise;
		$rose(trigger_filtered);
	endsequence
	a_start_one: assert property (exposure_start |=> !exposure_start)
		else $error("start pulse too long");
	a_rise_start: assert property ($rose(exposure_active) |-> exposure_start)
		else $error("exposure without start");
	a_start_act: assert property (exposure_start |-> exposure_active)
		else $error("start outside exposure");
	a_tick_one: assert property (line_tick |=> !line_tick)
		else $error("line tick too long");
	a_filt_rise: assert property (
		$rose(trigger_filtered) |-> $past(trigger_in ^ cfg.polarity_neg))
		else $error("filter rose on inactive input");
	a_start_filt: assert property (exposure_start |-> s_rise)
		else $error("start without filtered edge");
	a_pulse_hold: assert property (
		cfg.mode == etc_pkg::ETC_MODE_PULSE_WIDTH && exposure_active |-> trigger_filtered)
		else $error("pulse exposure outlives trigger");
	a_pulse_end: assert property (
		cfg.mode == etc_pkg::ETC_MODE_PULSE_WIDTH && $fell(trigger_filtered)
		|-> !exposure_active)
		else $error("pulse exposure did not end");
	a_timed_end: assert property (
		cfg.mode != etc_pkg::ETC_MODE_PULSE_WIDTH && $fell(exposure_active)
		|-> $past(line_tick))
		else $error("timed exposure ended off a line");
	a_busy_drop: assert property (
		exposure_start && $past(cfg.mode) == etc_pkg::ETC_MODE_EDGE_OVERLAP
		|-> !$past(image_out_busy))
		else $error("start taken while output busy");
endmodule
`default_nettype wire

// ==== etc_exposure_trigger_control.sv ====
`timescale 1ns/100ps
`default_nettype none

// Function
// - pulse-width mode with positive polarity exposes from trigger rise to trigger fall.
// - pulse-width mode with negative polarity exposes from trigger fall to trigger rise.
// - edge-preset mode starts on the active edge and exposes for the preset time only.
// - in the overlap edge-preset mode triggers during exposure or image output are dropped.
// - trigger pulses shorter than the filter time are removed and cause no exposure.
// - mono8 and mono10 use a line period of 9.428 us as timing unit.
// - mono12 uses a line period of 13.091 us as timing unit.
// - all lines of a frame share one exposure duration.
// - exposure_active is high during exposure and low once it completes.
module etc_exposure_trigger_control (
	// clock and reset
	input  wire logic               mclk,
	input  wire logic               rst_b,
	// configuration
	input  wire etc_pkg::etc_cfg_t  cfg,
	// trigger input, synchronous to mclk
	input  wire logic               trigger_in,
	// sensor side
	input  wire logic               image_out_busy,
	output logic                    exposure_active,
	output logic                    exposure_start,
	output logic                    line_tick,
	output logic                    trigger_filtered
);

	// ------------------------------------------------------------
	// line period divider
	// ------------------------------------------------------------
	logic [etc_pkg::LINE_CNT_W-1:0] line_cnt_r, line_cnt_nxt;
	logic [etc_pkg::LINE_CNT_W-1:0] line_max;
	logic                           line_tick_r, line_tick_nxt;
	logic                           restart_line;

	// one divider, length picked by pixel format; the period rounds down to whole
	// clock cycles, so a line can run up to one clock short of its nominal length
	always_comb begin
		if (cfg.fmt == etc_pkg::ETC_FMT_MONO12) begin
			line_max = etc_pkg::LINE_CNT_W'(etc_pkg::LINE_CYC_MONO12 - 1);
		end else begin
			line_max = etc_pkg::LINE_CNT_W'(etc_pkg::LINE_CYC_MONO8_10 - 1);
		end
	end

	// restarted at exposure start so the first line is whole
	always_comb begin
		line_tick_nxt = 1'b0;
		if (restart_line) begin
			line_cnt_nxt = '0;
		end else if (line_cnt_r >= line_max) begin
			line_cnt_nxt  = '0;
			line_tick_nxt = 1'b1;
		end else begin
			line_cnt_nxt = line_cnt_r + 1'b1;
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			line_cnt_r  <= '0;
			line_tick_r <= 1'b0;
		end else begin
			line_cnt_r  <= line_cnt_nxt;
			line_tick_r <= line_tick_nxt;
		end
	end

	// ------------------------------------------------------------
	// shared count decode
	// ------------------------------------------------------------
	// true once the sample now being counted completes a run of limit samples;
	// done in one extra bit so a count at full scale cannot wrap to zero and miss the limit,
	// and a limit of zero behaves as one so a zero setting never stalls
	function automatic logic limit_hit(
		input logic [etc_pkg::EXP_W-1:0] count,
		input logic [etc_pkg::EXP_W-1:0] limit
	);
		logic [etc_pkg::EXP_W:0] run;
		run       = {1'b0, count} + 1'b1;
		limit_hit = (run >= {1'b0, limit});
	endfunction

	// ------------------------------------------------------------
	// trigger filter
	// ------------------------------------------------------------
	logic                      trig_act;
	logic                      filt_done;
	logic                      filt_r, filt_nxt;
	logic [etc_pkg::FILT_W-1:0] filt_cnt_r, filt_cnt_nxt;

	// normalise to active-high so the filter only sees one polarity
	assign trig_act = trigger_in ^ cfg.polarity_neg;

	// the sample being taken now completes a run of filter-time differing samples
	assign filt_done = limit_hit(etc_pkg::EXP_W'(filt_cnt_r),
	                             etc_pkg::EXP_W'(cfg.trigger_filter_time));

	// the filtered level flips only after the raw level has differed for the
	// full filter time; both edges are filtered, costing that delay on each.
	// a pulse of exactly the filter time passes, so a source that keeps the
	// minimum width is never lost; anything shorter leaves no trace
	always_comb begin
		filt_nxt     = filt_r;
		filt_cnt_nxt = '0;
		if (trig_act != filt_r) begin
			if (filt_done) begin
				filt_nxt = trig_act;
			end else begin
				filt_cnt_nxt = filt_cnt_r + 1'b1;
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			filt_r     <= 1'b0;
			filt_cnt_r <= '0;
		end else begin
			filt_r     <= filt_nxt;
			filt_cnt_r <= filt_cnt_nxt;
		end
	end

	logic act_edge, inact_edge;
	assign act_edge   = filt_nxt & ~filt_r;
	assign inact_edge = ~filt_nxt & filt_r;

	// ------------------------------------------------------------
	// exposure control
	// ------------------------------------------------------------
	etc_pkg::etc_state_t        state_r, state_nxt;
	logic [etc_pkg::EXP_W-1:0]  exp_cnt_r, exp_cnt_nxt;
	logic                       start_r, start_nxt;
	logic                       busy_block;

	// overlap mode drops edges while the last frame is still going out
	assign busy_block = (cfg.mode == etc_pkg::ETC_MODE_EDGE_OVERLAP) && image_out_busy;

	// mode is sampled at each trigger; preset duration and format are read live, so a change to them hits the running exposure
	always_comb begin
		state_nxt    = state_r;
		exp_cnt_nxt  = exp_cnt_r;
		start_nxt    = 1'b0;
		restart_line = 1'b0;
		case (state_r)
			etc_pkg::ETC_ST_IDLE: begin
				if (act_edge && !busy_block) begin
					start_nxt    = 1'b1;
					restart_line = 1'b1;
					exp_cnt_nxt  = '0;
					if (cfg.mode == etc_pkg::ETC_MODE_PULSE_WIDTH) begin
						state_nxt = etc_pkg::ETC_ST_PULSE;
					end else begin
						state_nxt = etc_pkg::ETC_ST_TIMED;
					end
				end
			end
			etc_pkg::ETC_ST_PULSE: begin
				// ends on the inactive edge of the filtered trigger
				if (inact_edge) begin
					state_nxt = etc_pkg::ETC_ST_IDLE;
				end
			end
			etc_pkg::ETC_ST_TIMED: begin
				// trigger level ignored; edges here are dropped
				// a preset of zero acts as one line, never as an endless exposure
				if (line_tick_r) begin
					if (limit_hit(exp_cnt_r, cfg.preset_exposure_duration)) begin
						state_nxt = etc_pkg::ETC_ST_IDLE;
					end else begin
						exp_cnt_nxt = exp_cnt_r + 1'b1;
					end
				end
			end
			default: begin
				state_nxt = etc_pkg::ETC_ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			state_r   <= etc_pkg::ETC_ST_IDLE;
			exp_cnt_r <= '0;
			start_r   <= 1'b0;
		end else begin
			state_r   <= state_nxt;
			exp_cnt_r <= exp_cnt_nxt;
			start_r   <= start_nxt;
		end
	end

	// ------------------------------------------------------------
	// exposure indication
	// ------------------------------------------------------------
	logic active_r, active_nxt;

	// taken from the next state so the pin comes straight from a flip-flop yet
	// rises and falls on the same edges as the state register
	always_comb begin
		active_nxt = (state_nxt != etc_pkg::ETC_ST_IDLE);
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			active_r <= 1'b0;
		end else begin
			active_r <= active_nxt;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	// one global shutter window, so every line shares the duration
	assign exposure_active  = active_r;
	assign exposure_start   = start_r;
	assign line_tick        = line_tick_r;
	assign trigger_filtered = filt_r;

endmodule

`default_nettype wire

// ==== etc_pkg.sv ====
`default_nettype none
package etc_pkg;

	// ------------------------------------------------------------
	// clock and line timing
	// ------------------------------------------------------------
	localparam int unsigned CLK_MHZ          = 50;
	localparam int unsigned LINE_NS_MONO8_10 = 9428;   // 9.428 us
	localparam int unsigned LINE_NS_MONO12   = 13091;  // 13.091 us
	localparam int unsigned CLK_PERIOD_NS    = 1000 / CLK_MHZ;
	// longest time: round down
	localparam int unsigned LINE_CYC_MONO8_10 = LINE_NS_MONO8_10 / CLK_PERIOD_NS;
	localparam int unsigned LINE_CYC_MONO12   = LINE_NS_MONO12 / CLK_PERIOD_NS;

	// ------------------------------------------------------------
	// widths and encodings
	// ------------------------------------------------------------
	localparam int unsigned LINE_CNT_W = 10;
	localparam int unsigned FILT_W     = 16;
	localparam int unsigned EXP_W      = 24;

	typedef enum logic [1:0] {
		ETC_MODE_PULSE_WIDTH = 2'h0,
		ETC_MODE_EDGE_PRESET = 2'h1,
		ETC_MODE_EDGE_OVERLAP = 2'h2
	} etc_mode_t;

	typedef enum logic [1:0] {
		ETC_FMT_MONO8  = 2'h0,
		ETC_FMT_MONO10 = 2'h1,
		ETC_FMT_MONO12 = 2'h2
	} etc_fmt_t;

	typedef enum logic [1:0] {
		ETC_ST_IDLE  = 2'h0,
		ETC_ST_PULSE = 2'h1,
		ETC_ST_TIMED = 2'h2
	} etc_state_t;

	// configuration carried as one bundle
	typedef struct packed {
		etc_mode_t        mode;
		logic             polarity_neg;
		etc_fmt_t         fmt;
		logic [FILT_W-1:0] trigger_filter_time;       // clock cycles
		logic [EXP_W-1:0]  preset_exposure_duration;  // line periods
	} etc_cfg_t;

endpackage

`default_nettype wire

// ==== etc_trig_src.sv ====
`timescale 1ns/100ps
`default_nettype none
// ----
// external trigger source
// ----
module etc_trig_src (
	// clock and polarity
	input wire logic mclk,
	input wire logic neg,
	// trigger line
	output logic     trig
);
	logic act_r;
	initial act_r = 1'b0;
	// the line idles at its inactive level, so a polarity change makes no active edge
	assign trig = act_r ^ neg;
	// active level for w cycles; widths below the filter only when a run asks
	task automatic pulse(input int w);
		@(posedge mclk);
		act_r <= 1'b1;
		repeat (w) @(posedge mclk);
		act_r <= 1'b0;
	endtask
endmodule
`default_nettype wire

// ==== test_exposure_trigger_control.sv ====
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin errors++; $display("MISMATCH %0t %h %h", $time, a, b); end end
module test_exposure_trigger_control;
	logic              mclk, rst_b, image_out_busy, trigger_in, clr;
	logic              exposure_active, exposure_start, line_tick, trigger_filtered;
	etc_pkg::etc_cfg_t cfg;
	int                errors, checked, f, w;
	// four-state so an unknown output turns the count unknown and fails the compare
	integer            hi, hf, ns, nt, gap, gap_last;
	// ----
	// design and trigger source
	// ----
	etc_exposure_trigger_control dut_u (.mclk(mclk), .rst_b(rst_b), .cfg(cfg),
		.trigger_in(trigger_in), .image_out_busy(image_out_busy),
		.exposure_active(exposure_active), .exposure_start(exposure_start),
		.line_tick(line_tick), .trigger_filtered(trigger_filtered));
	etc_trig_src src_u (.mclk(mclk), .neg(cfg.polarity_neg), .trig(trigger_in));
	always #10 mclk = ~mclk;
	function automatic int line_len(input etc_pkg::etc_fmt_t t);
		return (t == etc_pkg::ETC_FMT_MONO12) ? etc_pkg::LINE_CYC_MONO12 : etc_pkg::LINE_CYC_MONO8_10;
	endfunction
	task automatic results;
		if (errors == 0 && checked > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	// starts, exposed and filtered-high cycles, in-exposure ticks and the last
	// in-exposure line length of a run, taken on the falling edge where the
	// registered outputs have settled; cleared only through clr
	always @(negedge mclk) begin
		if (clr) begin
			ns       <= 0;
			hi       <= 0;
			hf       <= 0;
			nt       <= 0;
			gap_last <= 0;
		end else begin
			ns <= ns + exposure_start;
			hi <= hi + exposure_active;
			hf <= hf + trigger_filtered;
			nt <= nt + (line_tick & exposure_active);
			if (line_tick && exposure_active && nt > 0)
				gap_last <= gap + 1;
		end
		gap <= line_tick ? 0 : gap + 1;
	end
	// one run: set mode, fire, then wait (bounded) until exposure is over
	task automatic go(input int m, input int pw, input int d);
		int k;
		@(posedge mclk);
		cfg.mode <= etc_pkg::etc_mode_t'(2'(m));
		cfg.preset_exposure_duration <= 24'(d);
		repeat (f + 3) @(posedge mclk);
		clr <= 1'b1;
		@(posedge mclk);
		clr <= 1'b0;
		src_u.pulse(pw);
		// a second edge inside a timed exposure has to be dropped
		if (m > 0) begin
			repeat (f + 2) @(posedge mclk);
			src_u.pulse(pw);
		end
		k = 0;
		while ((exposure_active || k < f + 4) && k < 3000) begin
			@(posedge mclk);
			k++;
		end
		if (k >= 3000) begin
			errors++;
			results();
		end
	endtask
	// ----
	// test sequence
	// ----
	initial begin
		mclk = 1'b0;
		rst_b = 1'b0;
		clr = 1'b1;
		image_out_busy = 1'b0;
		cfg = '0;
		void'($urandom(32'h0935));
		repeat (5) @(posedge mclk);
		rst_b <= 1'b1;
		for (int p = 0; p < 2; p++)
			for (int m = 0; m < 3; m++) begin
				f = 2 + $urandom % 8;
				@(posedge mclk);
				cfg.polarity_neg <= p[0];
				cfg.fmt <= etc_pkg::etc_fmt_t'(2'($urandom % 3));
				cfg.trigger_filter_time <= 16'(f);
				go(m, f - 1, 2);
				`CHK(ns, 0)
				`CHK(hf, 0)
				// the first pass uses a pulse of exactly the filter time, the shortest legal one
				w = (p == 0 && m == 0) ? f : f + $urandom % 20;
				go(m, w, 2 - m / 2);
				`CHK(ns, 1)
				`CHK(hf, (m > 0 ? 2 : 1) * w)
				if (m == 0) `CHK(hi, w)
				else `CHK(nt, 2 - m / 2)
				if (m > 0) `CHK(hi, (2 - m / 2) * line_len(cfg.fmt) + 1)
				if (m == 1) `CHK(gap_last, line_len(cfg.fmt))
			end
		image_out_busy <= 1'b1;
		go(2, f + 1, 1);
		`CHK(ns, 0)
		`CHK(hf, 2 * (f + 1))
		// plain edge-preset mode does not look at image output
		go(1, f + 1, 1);
		`CHK(ns, 1)
		results();
	end
endmodule
bind etc_exposure_trigger_control etc_chk chk_u (.mclk(mclk), .rst_b(rst_b), .cfg(cfg),
	.trigger_in(trigger_in), .image_out_busy(image_out_busy),
	.exposure_active(exposure_active), .exposure_start(exposure_start),
	.line_tick(line_tick), .trigger_filtered(trigger_filtered));
`default_nettype wire
